//--- core/dcrc_pkg.sv
// Constants, register map and carrier types of the DMA channel request configuration block
package dcrc_pkg;

   // ==========================================================
   // Bus geometry
   localparam int ADDR_W = 20;
   localparam int DATA_W = 32;

   // ==========================================================
   // Register indices (byte address is four times the index)
   localparam logic [15:0] IDX_CLRBP = 16'hf00c;
   localparam logic [15:0] IDX_CFG = 16'hf830;
   localparam logic [15:0] IDX_OVFE = 16'hf01d;
   localparam logic [15:0] IDX_IEN = 16'hf01c;
   localparam logic [15:0] IDX_IS = 16'hf019;
   localparam logic [15:0] IDX_STS = 16'hf040;
   localparam logic [15:0] IDX_CMD1 = 16'hf041;
   localparam logic [15:0] IDX_BP_BASE = 16'hf000;
   localparam logic [15:0] IDX_REQ_BP_BASE = 16'hf050;
   localparam logic [15:0] IDX_FULL_BASE = 16'hf060;
   localparam logic [15:0] BP_SPAN = 16'h0004;
   localparam logic [15:0] REQ_BP_SPAN = 16'h0002;
   localparam logic [15:0] FULL_SPAN = 16'h0006;
   localparam logic [15:0] FULL_PER_CH = 16'h0003;

   // ==========================================================
   // Field positions
   localparam int CFG_CH0_SEL_LSB = 0;
   localparam int CFG_CH0_MASK_BIT = 3;
   localparam int CFG_CH1_SEL_LSB = 4;
   localparam int CFG_CH1_MASK_BIT = 7;
   localparam int OVFE_TAR_BIT0 = 0;   // Channel n target bit is 2n
   localparam int OVFE_REQ_BIT0 = 1;   // Channel n requester bit is 2n+1
   localparam int CMD1_DISABLE_BIT = 2;
   localparam int CMD1_ROTATE_BIT = 4;
   localparam int STS_TC_LSB = 0;
   localparam int STS_REQ_LSB = 4;

   // ==========================================================
   // Reset values
   localparam logic [7:0] CFG_RESET = 8'h00;
   localparam logic [7:0] OVFE_RESET = 8'h00;
   localparam logic [7:0] CMD1_RESET = 8'h00;
   localparam logic [7:0] IEN_RESET = 8'h00;

   // ==========================================================
   // Field widths of the channel registers
   localparam int REQ_W = 26;
   localparam int TAR_W = 26;
   localparam int BYC_W = 24;
   localparam int LOW_W = 16;

   // ==========================================================
   // Carrier types
   typedef struct packed {
      logic serial0_rx_full;
      logic serial1_rx_full;
      logic serial0_tx_empty;
      logic serial1_tx_empty;
      logic sync_serial_rx_full;
      logic sync_serial_tx_empty;
      logic timer1_output;
      logic timer2_output;
   } dcrc_sources_t;

   typedef struct packed {
      logic [REQ_W-1:0] req;
      logic [TAR_W-1:0] tar;
      logic [BYC_W-1:0] byc;
   } dcrc_chan_t;

   typedef enum logic [1:0] {KIND_REQ, KIND_TAR, KIND_BYC} dcrc_kind_t;

endpackage

//--- core/dcrc_req_route.sv
// Request source router for one channel, with pin synchroniser
`timescale 1ns/1ps
`default_nettype none
module dcrc_req_route
   import dcrc_pkg::*;
#(
   parameter bit CHANNEL = 1'b0
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic request_pin,
   input wire dcrc_sources_t sources,
   input wire logic [2:0] source_select,
   output logic routed_request
);

   logic [2:0] pin_sync_reg;
   logic pin_level_reg;
   logic [7:0] by_code;

   // ==========================================================
   // Pin synchroniser: stage 0 feeds stage 1 only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_sync_reg <= 3'h0;
      end else begin
         pin_sync_reg <= {pin_sync_reg[1:0], request_pin};
      end
   end

   // Level accepted once the two later stages agree
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_level_reg <= 1'b0;
      end else if (pin_sync_reg[1] == pin_sync_reg[2]) begin
         pin_level_reg <= pin_sync_reg[2];
      end
   end

   // ==========================================================
   // Sources laid out by select code; internal units share our clock
   always_comb begin
      if (CHANNEL) begin
         by_code = {sources.sync_serial_tx_empty, sources.serial1_tx_empty,
                    sources.serial0_rx_full, sources.timer2_output,
                    sources.sync_serial_rx_full, sources.serial0_tx_empty,
                    sources.serial1_rx_full, pin_level_reg};
      end else begin
         by_code = {sources.sync_serial_rx_full, sources.serial0_tx_empty,
                    sources.serial1_rx_full, sources.timer1_output,
                    sources.sync_serial_tx_empty, sources.serial1_tx_empty,
                    sources.serial0_rx_full, pin_level_reg};
      end
   end

   assign routed_request = by_code[source_select];

endmodule
`default_nettype wire

//--- core/dcrc_channel_config.sv
// Two-channel DMA request routing, byte pointer, channel registers and status
//
// How it works
// - channel 0 source select routes eight sources
// - channel 1 source select routes eight sources
// - bit 7 masks channel 1 acknowledge
// - bit 3 masks channel 0 acknowledge
// - byte-pointer access toggles the byte pointer
// - clear-pointer write forces pointer to zero
// - requester steps 16 or 26 bits
// - target and count step 16 or full
// - 16-bit count expires on 0000 to ffff
// - status shows pending hardware request per channel
// - status shows expired count per channel
// - command enables channels, selects rotating priority
// - configuration readable, writable, resets to zero
// - per-channel interrupt enable, readable source status
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module dcrc_channel_config
   import dcrc_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [DATA_W-1:0] pwdata,
   output logic [DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic ch0_request_pin,
   input wire logic ch1_request_pin,
   input wire dcrc_sources_t sources,
   input wire logic [1:0] xfer_ack,
   input wire logic [1:0] xfer_step,
   input wire logic [1:0] xfer_addr_down,
   output logic ch0_request_in,
   output logic ch1_request_in,
   output logic ch0_ack_out_n,
   output logic ch1_ack_out_n,
   output logic channels_enabled,
   output logic rotating_priority,
   output logic byte_pointer_flag,
   output dcrc_chan_t ch0_state,
   output dcrc_chan_t ch1_state,
   output logic transfer_irq_out
);

   // ==========================================================
   // Functions

   // One step of an address or count; narrow mode keeps bits above 15
   function automatic logic [REQ_W-1:0] dcrc_step(input logic [REQ_W-1:0] v,
                                                  input logic wide,
                                                  input logic down);
      logic [REQ_W-1:0] d;
      d = down ? v - REQ_W'(1) : v + REQ_W'(1);
      return wide ? d : {v[REQ_W-1:LOW_W], d[LOW_W-1:0]};
   endfunction

   // Replace the pointed byte of the low half
   function automatic logic [REQ_W-1:0] dcrc_put_byte(input logic [REQ_W-1:0] v,
                                                      input logic hi,
                                                      input logic [7:0] b);
      return hi ? {v[REQ_W-1:LOW_W], b, v[7:0]} : {v[REQ_W-1:8], b};
   endfunction

   // Field of a channel by kind, zero extended
   function automatic logic [REQ_W-1:0] dcrc_get(input dcrc_chan_t c,
                                                 input dcrc_kind_t k);
      case (k)
         KIND_REQ: return c.req;
         KIND_TAR: return c.tar;
         default: return REQ_W'(c.byc);
      endcase
   endfunction

   // ==========================================================
   // Declarations
   logic [15:0] idx;
   logic [15:0] bp_off;
   logic [15:0] rq_off;
   logic [15:0] full_off;
   logic aligned;
   logic map_hit;
   logic bp_acc;
   logic full_acc;
   logic sel_ch;
   dcrc_kind_t sel_kind;
   logic acc_phase;
   logic done;
   logic wr_done;
   logic rd_done;
   logic pready_reg;
   logic pslverr_reg;
   logic [DATA_W-1:0] prdata_reg;
   logic [DATA_W-1:0] rd_data;
   logic [REQ_W-1:0] sel_field;
   logic [7:0] cfg_reg;
   logic [7:0] ovfe_reg;
   logic [7:0] cmd1_reg;
   logic [7:0] ien_reg;
   logic [1:0] tc_reg;
   logic [1:0] tc_clr;
   logic [1:0] expire;
   logic bp_reg;
   logic irq_reg;
   logic [1:0] routed;
   dcrc_chan_t chan_reg [2];

   // ==========================================================
   // Request routing per channel
   dcrc_req_route #(.CHANNEL(1'b0)) u_route0 (
      .pclk(pclk),
      .presetn(presetn),
      .request_pin(ch0_request_pin),
      .sources(sources),
      .source_select(cfg_reg[CFG_CH0_SEL_LSB +: 3]),
      .routed_request(routed[0])
   );

   dcrc_req_route #(.CHANNEL(1'b1)) u_route1 (
      .pclk(pclk),
      .presetn(presetn),
      .request_pin(ch1_request_pin),
      .sources(sources),
      .source_select(cfg_reg[CFG_CH1_SEL_LSB +: 3]),
      .routed_request(routed[1])
   );

   // ==========================================================
   // Address decode
   assign idx = paddr[17:2];
   assign aligned = (paddr[ADDR_W-1:18] == 2'h0) && (paddr[1:0] == 2'h0);
   assign bp_off = idx - IDX_BP_BASE;
   assign rq_off = idx - IDX_REQ_BP_BASE;
   assign full_off = idx - IDX_FULL_BASE;

   // Which channel field an access reaches, and whether through the pointer
   always_comb begin
      bp_acc = 1'b0;
      full_acc = 1'b0;
      sel_ch = 1'b0;
      sel_kind = KIND_TAR;
      if (bp_off < BP_SPAN) begin
         bp_acc = 1'b1;
         sel_ch = bp_off[1];
         sel_kind = bp_off[0] ? KIND_BYC : KIND_TAR;
      end else if (rq_off < REQ_BP_SPAN) begin
         bp_acc = 1'b1;
         sel_ch = rq_off[0];
         sel_kind = KIND_REQ;
      end else if (full_off < FULL_SPAN) begin
         full_acc = 1'b1;
         sel_ch = (full_off >= FULL_PER_CH);
         sel_kind = dcrc_kind_t'(sel_ch ? full_off[1:0] - 2'(FULL_PER_CH)
                                        : full_off[1:0]);
      end
   end

   assign map_hit = aligned && (bp_acc || full_acc || idx == IDX_CLRBP ||
                    idx == IDX_CFG || idx == IDX_OVFE || idx == IDX_IEN ||
                    idx == IDX_IS || idx == IDX_STS || idx == IDX_CMD1);
   assign sel_field = dcrc_get(chan_reg[sel_ch], sel_kind);

   // ==========================================================
   // Read data
   always_comb begin
      rd_data = '0;
      if (bp_acc) begin
         rd_data[7:0] = bp_reg ? sel_field[15:8] : sel_field[7:0];
      end else if (full_acc) begin
         rd_data = DATA_W'(sel_field);
      end else begin
         case (idx)
            IDX_CFG: rd_data[7:0] = cfg_reg;
            IDX_OVFE: rd_data[7:0] = ovfe_reg;
            IDX_CMD1: rd_data[7:0] = cmd1_reg;
            IDX_IEN: rd_data[7:0] = ien_reg;
            IDX_IS: rd_data[1:0] = tc_reg & ien_reg[1:0];
            IDX_STS: begin
               rd_data[STS_TC_LSB +: 2] = tc_reg;
               rd_data[STS_REQ_LSB +: 2] = routed;
            end
            default: rd_data = '0;
         endcase
      end
   end

   // ==========================================================
   // APB slave: one wait cycle so read data leaves a flip-flop
   assign acc_phase = psel & penable;
   assign done = acc_phase & pready_reg;
   assign wr_done = done & pwrite & map_hit;
   assign rd_done = done & ~pwrite & map_hit;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= '0;
      end else begin
         pready_reg <= acc_phase & ~pready_reg;
         if (acc_phase && !pready_reg) begin
            prdata_reg <= (pwrite || !map_hit) ? '0 : rd_data;
            pslverr_reg <= ~map_hit;
         end
      end
   end

   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign prdata = prdata_reg;

   // ==========================================================
   // Control registers; reserved overflow bits are stored as written
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_reg <= CFG_RESET;
         ovfe_reg <= OVFE_RESET;
         cmd1_reg <= CMD1_RESET;
         ien_reg <= IEN_RESET;
      end else if (wr_done) begin
         case (idx)
            IDX_CFG: cfg_reg <= pwdata[7:0];
            IDX_OVFE: ovfe_reg <= pwdata[7:0];
            IDX_CMD1: cmd1_reg <= pwdata[7:0];
            IDX_IEN: ien_reg <= pwdata[7:0];
            default: ;
         endcase
      end
   end

   // ==========================================================
   // Byte pointer: clear command wins, else toggle on every pointer access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bp_reg <= 1'b0;
      end else if (wr_done && idx == IDX_CLRBP) begin
         bp_reg <= 1'b0;
      end else if ((wr_done || rd_done) && bp_acc) begin
         bp_reg <= ~bp_reg;
      end
   end

   // ==========================================================
   // Count expiry at the step taken from zero
   always_comb begin
      for (int c = 0; c < 2; c++) begin
         if (ovfe_reg[OVFE_TAR_BIT0 + 2 * c]) begin
            expire[c] = xfer_step[c] & (chan_reg[c].byc == '0);
         end else begin
            expire[c] = xfer_step[c] & (chan_reg[c].byc[LOW_W-1:0] == '0);
         end
      end
   end

   // ==========================================================
   // Channel registers: software writes win over a step in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         chan_reg[0] <= '0;
         chan_reg[1] <= '0;
      end else begin
         for (int c = 0; c < 2; c++) begin
            if (xfer_step[c]) begin
               chan_reg[c].req <= dcrc_step(chan_reg[c].req,
                                            ovfe_reg[OVFE_REQ_BIT0 + 2 * c],
                                            xfer_addr_down[c]);
               chan_reg[c].tar <= dcrc_step(chan_reg[c].tar,
                                            ovfe_reg[OVFE_TAR_BIT0 + 2 * c],
                                            xfer_addr_down[c]);
               chan_reg[c].byc <= BYC_W'(dcrc_step(REQ_W'(chan_reg[c].byc),
                                            ovfe_reg[OVFE_TAR_BIT0 + 2 * c],
                                            1'b1));
            end
            if (wr_done && (bp_acc || full_acc) && sel_ch == 1'(c)) begin
               case (sel_kind)
                  KIND_REQ: chan_reg[c].req <= bp_acc
                     ? dcrc_put_byte(chan_reg[c].req, bp_reg, pwdata[7:0])
                     : pwdata[REQ_W-1:0];
                  KIND_TAR: chan_reg[c].tar <= bp_acc
                     ? dcrc_put_byte(chan_reg[c].tar, bp_reg, pwdata[7:0])
                     : pwdata[TAR_W-1:0];
                  default: chan_reg[c].byc <= bp_acc
                     ? BYC_W'(dcrc_put_byte(REQ_W'(chan_reg[c].byc), bp_reg,
                                            pwdata[7:0]))
                     : pwdata[BYC_W-1:0];
               endcase
            end
         end
      end
   end

   // ==========================================================
   // Expiry flags: a status read clears them, a new expiry wins
   assign tc_clr = (rd_done && idx == IDX_STS) ? 2'h3 : 2'h0;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tc_reg <= 2'h0;
      end else begin
         tc_reg <= (tc_reg & ~tc_clr) | expire;
      end
   end

   // Interrupt output from a flip-flop, one cycle behind the flags
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= |(tc_reg & ien_reg[1:0]);
      end
   end

   // ==========================================================
   // Outputs to the transfer engine and pins
   assign channels_enabled = ~cmd1_reg[CMD1_DISABLE_BIT];
   assign rotating_priority = cmd1_reg[CMD1_ROTATE_BIT];
   assign ch0_request_in = routed[0] & channels_enabled;
   assign ch1_request_in = routed[1] & channels_enabled;
   // Mask keeps internal requesters from driving the pin acknowledge
   assign ch0_ack_out_n = ~(xfer_ack[0] & ~cfg_reg[CFG_CH0_MASK_BIT]);
   assign ch1_ack_out_n = ~(xfer_ack[1] & ~cfg_reg[CFG_CH1_MASK_BIT]);
   assign byte_pointer_flag = bp_reg;
   assign ch0_state = chan_reg[0];
   assign ch1_state = chan_reg[1];
   assign transfer_irq_out = irq_reg;

endmodule
`default_nettype wire

//--- dv/dcrc_source_model.sv
// Behavioural model of the internal requesters and the external request pins
`timescale 1ns/1ps
`default_nettype none
module dcrc_source_model
   import dcrc_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic load,
   input wire logic [9:0] level,
   output dcrc_sources_t sources,
   output logic ch0_request_pin,
   output logic ch1_request_pin
);
   // ==========================================================
   // Request levels
   // A peripheral's flag holds its level until serviced, so levels stay between loads
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {ch1_request_pin, ch0_request_pin, sources} <= 10'h000;
      end else if (load) begin
         {ch1_request_pin, ch0_request_pin, sources} <= level;
      end
   end
endmodule
`default_nettype wire

//--- dv/dcrc_channel_config_sva.sv
// Checker of bus timing, byte pointer, acknowledge masks and stepping widths
`timescale 1ns/1ps
`default_nettype none
module dcrc_channel_config_sva
   import dcrc_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [DATA_W-1:0] pwdata,
   input wire logic pready,
   input wire logic [1:0] xfer_ack,
   input wire logic [1:0] xfer_step,
   input wire logic ch0_request_in,
   input wire logic ch1_request_in,
   input wire logic ch0_ack_out_n,
   input wire logic ch1_ack_out_n,
   input wire logic channels_enabled,
   input wire logic rotating_priority,
   input wire logic byte_pointer_flag,
   input wire dcrc_chan_t ch0_state,
   input wire dcrc_chan_t ch1_state
);
   // ==========================================================
   // Helper logic
   logic [7:0] cfg_reg;
   logic [7:0] ovfe_reg;
   logic done, wr_done, ptr_acc, rot_bit, dis_bit;
   logic [15:0] idx, c0_lo, r1_lo;
   logic [7:0] c0_hi;
   logic [9:0] r1_hi;
   assign idx = paddr[17:2];
   assign done = psel & penable & pready;
   assign wr_done = done & pwrite;
   assign ptr_acc = done && ((idx >= IDX_BP_BASE && idx < IDX_BP_BASE + BP_SPAN) ||
      (idx >= IDX_REQ_BP_BASE && idx < IDX_REQ_BP_BASE + REQ_BP_SPAN));
   assign {rot_bit, dis_bit} = {pwdata[CMD1_ROTATE_BIT], pwdata[CMD1_DISABLE_BIT]};
   assign {c0_hi, c0_lo} = ch0_state.byc;
   assign {r1_hi, r1_lo} = ch1_state.req;
   // Shadow copies, since the checker sees only the ports
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_reg <= 8'h00;
         ovfe_reg <= 8'h00;
      end else if (wr_done) begin
         if (idx == IDX_CFG) cfg_reg <= pwdata[7:0];
         if (idx == IDX_OVFE) ovfe_reg <= pwdata[7:0];
      end
   end
   // ==========================================================
   // Properties
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_answer;
      !pready ##1 pready;
   endsequence
   a_ready_time: assert property (s_setup |=> s_answer)
      else $error("ready not on second access cycle");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   a_ptr_toggle: assert property (ptr_acc |=> byte_pointer_flag != $past(byte_pointer_flag))
      else $error("byte pointer did not toggle");
   a_ptr_clear: assert property (wr_done && idx == IDX_CLRBP |=> !byte_pointer_flag)
      else $error("byte pointer not cleared");
   a_ack_mask0: assert property (ch0_ack_out_n == !(xfer_ack[0] && !cfg_reg[3]))
      else $error("channel 0 acknowledge wrong");
   a_ack_mask1: assert property (ch1_ack_out_n == !(xfer_ack[1] && !cfg_reg[7]))
      else $error("channel 1 acknowledge wrong");
   a_req_gate: assert property (!channels_enabled |-> !ch0_request_in && !ch1_request_in)
      else $error("request passed while disabled");
   a_cmd_apply: assert property (wr_done && idx == IDX_CMD1 |=>
      rotating_priority == $past(rot_bit) && channels_enabled == !$past(dis_bit))
      else $error("command bits not applied");
   a_count_wrap: assert property (xfer_step[0] && !ovfe_reg[0] && !wr_done && c0_lo == 16'h0000
      |=> c0_lo == 16'hffff && $stable(c0_hi))
      else $error("narrow count did not wrap alone");
   a_req_narrow: assert property (xfer_step[1] && !ovfe_reg[3] && !wr_done
      |=> $stable(r1_hi) && r1_lo != $past(r1_lo))
      else $error("narrow requester stepped wrongly");
endmodule
`default_nettype wire

//--- dv/dcrc_channel_config_test.sv
// Self-checking bench of the channel request configuration block
`timescale 1ns/1ps
`default_nettype none
module dcrc_channel_config_test;
   import dcrc_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, load, rerr;
   logic [ADDR_W-1:0] paddr;
   logic [DATA_W-1:0] pwdata, prdata, rdat, r, lfsr;
   logic [1:0] xfer_ack, xfer_step, xfer_addr_down;
   logic [9:0] level;
   logic [7:0] cfg;
   logic ch0_request_pin, ch1_request_pin, ch0_request_in, ch1_request_in;
   logic ch0_ack_out_n, ch1_ack_out_n, channels_enabled, rotating_priority;
   logic byte_pointer_flag, transfer_irq_out;
   dcrc_sources_t sources;
   dcrc_chan_t ch0_state, ch1_state;
   int errors, check_count, cyc;

   dcrc_channel_config i_dcrc_channel_config (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .ch0_request_pin(ch0_request_pin),
      .ch1_request_pin(ch1_request_pin), .sources(sources), .xfer_ack(xfer_ack),
      .xfer_step(xfer_step), .xfer_addr_down(xfer_addr_down), .ch0_request_in(ch0_request_in),
      .ch1_request_in(ch1_request_in), .ch0_ack_out_n(ch0_ack_out_n),
      .ch1_ack_out_n(ch1_ack_out_n), .channels_enabled(channels_enabled),
      .rotating_priority(rotating_priority), .byte_pointer_flag(byte_pointer_flag),
      .ch0_state(ch0_state), .ch1_state(ch1_state), .transfer_irq_out(transfer_irq_out));
   dcrc_source_model i_dcrc_source_model (.pclk(pclk), .presetn(presetn), .load(load),
      .level(level), .sources(sources), .ch0_request_pin(ch0_request_pin),
      .ch1_request_pin(ch1_request_pin));

   // ==========================================================
   // Helpers
   function automatic logic route(input logic ch, input logic [2:0] c, input logic [9:0] v);
      int t0[8] = '{8, 7, 4, 2, 1, 6, 5, 3};
      int t1[8] = '{9, 6, 5, 3, 0, 7, 4, 2};
      return v[ch ? t1[c] : t0[c]];
   endfunction
   function logic [31:0] rnd();
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      return lfsr;
   endfunction
   task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   // One transfer; an idle edge first keeps select from being assigned twice in a step
   task apb(input logic wr, input logic [15:0] i, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {2'b00, i, 2'b00};
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task step(input logic [1:0] s);
      @(posedge pclk);
      xfer_step <= s;
      @(posedge pclk);
      xfer_step <= 2'b00;
      @(posedge pclk);
   endtask
   task wrap_up;
      $display("errors %0d checks %0d", errors, check_count);
      if (errors == 0 && check_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // ==========================================================
   // Clock and hang guard
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 5000) begin
         errors++;
         wrap_up();
      end
   end

   // ==========================================================
   // Main sequence
   initial begin
      {psel, penable, pwrite, load, xfer_ack, xfer_step, xfer_addr_down} = '0;
      {paddr, pwdata, level} = '0;
      {errors, check_count, cyc} = '0;
      lfsr = 32'h0001749f;
      presetn = 1'b0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, IDX_CFG, 32'h0);
      chk("cfg reset", 32'h0, rdat);
      chk("pointer reset", 32'h0, byte_pointer_flag);
      // Every source code on both channels, random masks, levels and acknowledges
      for (int k = 0; k < 8; k++) begin
         r = rnd();
         cfg = {r[1], 3'(7 - k), r[0], 3'(k)};
         apb(1'b1, IDX_CFG, {24'h0, cfg});
         apb(1'b0, IDX_CFG, 32'h0);
         chk("cfg readback", {24'h0, cfg}, rdat);
         load <= 1'b1;
         level <= r[17:8];
         xfer_ack <= r[19:18];
         @(posedge pclk);
         load <= 1'b0;
         repeat (5) @(posedge pclk);
         chk("ch0 request", route(1'b0, cfg[2:0], r[17:8]), ch0_request_in);
         chk("ch1 request", route(1'b1, cfg[6:4], r[17:8]), ch1_request_in);
         chk("ch0 ack", !(r[18] && !r[0]), ch0_ack_out_n);
         chk("ch1 ack", !(r[19] && !r[1]), ch1_ack_out_n);
         apb(1'b0, IDX_STS, 32'h0);
         chk("pending", {route(1'b1, cfg[6:4], r[17:8]), route(1'b0, cfg[2:0], r[17:8])},
            rdat[5:4]);
      end
      // Disable with every requester raised, rotating priority set in the same command write
      apb(1'b1, IDX_CFG, 32'h0);
      load <= 1'b1;
      level <= 10'h3ff;
      apb(1'b1, IDX_CMD1, 32'h14);
      load <= 1'b0;
      repeat (5) @(posedge pclk);
      chk("enabled", 32'h0, channels_enabled);
      chk("rotating", 32'h1, rotating_priority);
      chk("gated request", 32'h0, ch0_request_in);
      apb(1'b1, IDX_CMD1, 32'h0);
      @(posedge pclk);
      chk("enabled again", 32'h1, channels_enabled);
      // Byte pointer sequence
      apb(1'b1, IDX_BP_BASE, 32'h56);
      @(posedge pclk);
      chk("pointer toggled", 32'h1, byte_pointer_flag);
      apb(1'b1, IDX_CLRBP, rnd());
      @(posedge pclk);
      chk("pointer cleared", 32'h0, byte_pointer_flag);
      apb(1'b1, IDX_BP_BASE, 32'h34);
      apb(1'b1, IDX_BP_BASE, 32'h12);
      apb(1'b0, IDX_FULL_BASE + 16'h1, 32'h0);
      chk("target bytes", 32'h1234, rdat[15:0]);
      // Narrow count expiry raises status and the enabled interrupt
      apb(1'b1, IDX_IEN, 32'h1);
      apb(1'b1, IDX_FULL_BASE + 16'h2, 32'h00aa0000);
      xfer_addr_down <= 2'b01;
      step(2'b01);
      chk("narrow count", 32'haaffff, ch0_state.byc);
      chk("target down", 32'h1233, ch0_state.tar);
      chk("requester down", 32'hffff, ch0_state.req);
      @(posedge pclk);
      chk("irq", 32'h1, transfer_irq_out);
      apb(1'b0, IDX_IS, 32'h0);
      chk("irq source", 32'h1, rdat);
      apb(1'b0, IDX_STS, 32'h0);
      chk("expired", 32'h1, rdat[0]);
      // Wide count and requester widths; reserved bits written as zero
      apb(1'b1, IDX_OVFE, 32'h01);
      apb(1'b1, IDX_FULL_BASE + 16'h2, 32'h0);
      step(2'b01);
      chk("wide count", 32'hffffff, ch0_state.byc);
      for (int w = 0; w < 2; w++) begin
         apb(1'b1, IDX_OVFE, 32'(w * 8));
         apb(1'b1, IDX_FULL_BASE + FULL_PER_CH, 32'h0123ffff);
         step(2'b10);
         chk("ch1 requester", w ? 32'h1240000 : 32'h1230000, ch1_state.req);
      end
      // Unmapped place
      apb(1'b0, 16'h0123, 32'h0);
      chk("unmapped error", 32'h1, rerr);
      chk("unmapped data", 32'h0, rdat);
      wrap_up();
   end
endmodule

bind dcrc_channel_config dcrc_channel_config_sva i_dcrc_channel_config_sva (.pclk(pclk),
   .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .pready(pready), .xfer_ack(xfer_ack), .xfer_step(xfer_step),
   .ch0_request_in(ch0_request_in), .ch1_request_in(ch1_request_in),
   .ch0_ack_out_n(ch0_ack_out_n), .ch1_ack_out_n(ch1_ack_out_n),
   .channels_enabled(channels_enabled), .rotating_priority(rotating_priority),
   .byte_pointer_flag(byte_pointer_flag), .ch0_state(ch0_state), .ch1_state(ch1_state));
`default_nettype wire
